// file: bench/link_bank_checker.sv
`timescale 1ns/1ps
module link_bank_checker #(
  parameter int ADDR_W = 10
) (
  input wire logic mclk, // clock
  input wire logic nrst, // reset
  input wire logic [ADDR_W-1:0] awaddr, // bus
  input wire logic awvalid, // bus
  input wire logic awready, // bus
  input wire logic wvalid, // bus
  input wire logic wready, // bus
  input wire logic [1:0] bresp, // bus
  input wire logic bvalid, // bus
  input wire logic bready, // bus
  input wire logic [ADDR_W-1:0] araddr, // bus
  input wire logic arvalid, // bus
  input wire logic arready, // bus
  input wire logic [31:0] rdata, // bus
  input wire logic rvalid, // bus
  input wire link_status_pkg::hw_status_s hwStatus, // link status
  input wire logic [3:0] gpioPins, // pins
  input wire logic irq // interrupt
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // status held two cycles so the registered copy has caught up
  sequence statusRd;
    arvalid && arready && araddr[9:2] == 8'h52 && $past(nrst) && $past(nrst, 2)
      && hwStatus == $past(hwStatus) && hwStatus == $past(hwStatus, 2);
  endsequence
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  ro_write_a: assert property (awvalid && awready && wvalid && wready && awaddr[9:2] inside {[8'h51:8'h57]}
    |=> bresp == 2'h2) else $error("read-only write accepted");
  remote_lock_a: assert property (statusRd |=> rdata[6] == $past(hwStatus.remoteLocked))
    else $error("remote lock bit wrong");
  pll_lock_a: assert property (statusRd |=> rdata[2] == $past(hwStatus.fwdPllLocked))
    else $error("pll lock bit wrong");
  link_valid_a: assert property (statusRd |=> rdata[0] == $past(hwStatus.bcLinkValid))
    else $error("link detect bit wrong");
  gpio_levels_a: assert property (arvalid && arready && araddr[9:2] == 8'h53 && $past(nrst)
    && $past(nrst, 2) && gpioPins == $past(gpioPins) && gpioPins == $past(gpioPins, 2)
    && gpioPins == $past(gpioPins, 3) |=> rdata == {28'h0000000, $past(gpioPins)}) else $error("gpio levels wrong");
  cover property (bvalid && bready && bresp == 2'h2);
  cover property (irq);
  cover property (statusRd);
endmodule : link_bank_checker
bind link_status_bank link_bank_checker #(.ADDR_W(ADDR_W)) u_link_bank_checker (.*);

// file: bench/link_side_model.sv
`timescale 1ns/1ps
module link_side_model (
  input wire logic mclk, // register clock
  input wire logic nrst, // sync reset, active low
  input wire logic fire, // load a new burst
  input wire logic [7:0] crcBurst, // crc error pulses to send
  input wire logic [7:0] stBurst, // self-test error pulses to send
  input wire logic [4:0] levels, // init, checksum, remote lock, link, pll
  output link_status_pkg::hw_status_s hwStatus, // toward the bank
  output logic busy // burst still running
);
  logic [7:0] crcLeft;
  logic [7:0] stLeft;
  logic gap;
  logic crcPulse;
  logic stPulse;
  // an idle cycle between pulses so each one counts on its own
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      {crcLeft, stLeft, gap, crcPulse, stPulse} <= '0;
    end
    else if (fire)
    begin
      crcLeft <= crcBurst;
      stLeft <= stBurst;
    end
    else
    begin
      gap <= ~gap;
      crcPulse <= !gap && crcLeft != 8'h00;
      stPulse <= !gap && stLeft != 8'h00;
      if (!gap && crcLeft != 8'h00) crcLeft <= crcLeft - 8'h01;
      if (!gap && stLeft != 8'h00) stLeft <= stLeft - 8'h01;
    end
  end
  assign hwStatus = {levels, crcPulse, stPulse};
  assign busy = crcLeft != 8'h00 || stLeft != 8'h00 || crcPulse || stPulse;
endmodule : link_side_model

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, fire, busy;
  logic [9:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, gpioPins;
  logic [1:0] bresp, rresp, r;
  logic [7:0] crcBurst, stBurst, n;
  logic [4:0] levels;
  link_status_pkg::hw_status_s hwStatus;
  link_status_pkg::sensor_reading_s readings;
  int error_cnt, total_checks, seed, sh;
  link_status_bank u_link_status_bank (.*);
  link_side_model u_link_side_model (.*);
  always #5 mclk = ~mclk;
  task wrap_up;
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask : chk
  // general status image, bits 7 and 5 always zero
  function automatic logic [31:0] general(input logic rl, lost, stErr, pll, crc, link);
    general = {24'h000000, 1'b0, rl, 1'b0, lost, stErr, pll, crc, link};
  endfunction : general
  // irq sampled mid-cycle, away from the edge that launches it
  task automatic chkIrq(input logic e);
    @(negedge mclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge mclk);
  endtask : chkIrq
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick
  task automatic wr(input logic [7:0] i, input logic [7:0] v, input logic [1:0] e);
    logic a, w, b;
    logic [1:0] g;
    int k;
    k = 0;
    b = 1'b0;
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && k < 60)
    begin
      @(negedge mclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      g = bresp;
      k++;
      @(posedge mclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    if (!b)
    begin
      chk(32'hDEAD, 32'h0);
      wrap_up;
    end
    chk({30'h0, g}, {30'h0, e});
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [31:0] v, output logic [1:0] g);
    logic a, b;
    int k;
    k = 0;
    b = 1'b0;
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!b && k < 60)
    begin
      @(negedge mclk);
      a = arvalid && arready;
      b = rvalid;
      v = rdata;
      g = rresp;
      k++;
      @(posedge mclk);
      if (a) arvalid <= 1'b0;
    end
    if (!b)
    begin
      chk(32'hDEAD, 32'h0);
      wrap_up;
    end
  endtask : rd
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    rd(i, d, r);
    chk(d, e);
  endtask : rdc
  task automatic burst(input logic [7:0] c, input logic [7:0] s);
    int k;
    crcBurst <= c;
    stBurst <= s;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    for (k = 0; k < 700; k++)
    begin
      @(negedge mclk);
      if (!busy) break;
    end
    if (busy)
    begin
      chk(32'hDEAD, 32'h0);
      wrap_up;
    end
    tick(3);
  endtask : burst
  task automatic rst;
    nrst <= 1'b0;
    tick(16);
    nrst <= 1'b1;
    tick(1);
  endtask : rst
  initial
  begin
    {mclk, awvalid, wvalid, bready, arvalid, rready, fire} = '0;
    {awaddr, araddr, awprot, arprot, wdata, crcBurst, stBurst, gpioPins} = '0;
    wstrb = 4'hF;
    nrst = 1'b0;
    levels = 5'h03;
    readings = 24'h808080;
    seed = 64522;
    rst;
    rdc(8'h51, 32'h0);
    for (int i = 8'h54; i < 8'h58; i++) rdc(i[7:0], 32'h0);
    rd(8'h70, d, r);
    chk({d[31:2], r}, 32'h2);
    wr(8'h52, 8'hFF, 2'h2);
    levels <= 5'h1F;
    tick(3);
    rdc(8'h51, 32'hC0);
    wr(8'h69, 8'h1F, 2'h0);
    n = 8'($unsigned($random(seed)) % 20 + 1);
    burst(n, 8'h00);
    rdc(8'h55, {24'h0, n});
    rdc(8'h56, 32'h0);
    rdc(8'h52, general(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
    chkIrq(1'b1);
    rdc(8'h68, 32'h1);
    tick(2);
    chkIrq(1'b0);
    wr(8'h60, 8'h00, 2'h0);
    rdc(8'h52, general(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
    wr(8'h60, 8'h08, 2'h0);
    tick(2);
    rdc(8'h52, general(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1));
    rdc(8'h55, 32'h0);
    levels <= 5'h1D;
    tick(3);
    burst(8'h05, 8'h00);
    rdc(8'h52, general(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    rdc(8'h55, 32'h0);
    levels <= 5'h1C;
    tick(3);
    rdc(8'h52, general(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    levels <= 5'h1F;
    tick(3);
    rdc(8'h52, general(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
    wr(8'h60, 8'h08, 2'h0);
    tick(2);
    rdc(8'h52, general(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1));
    burst(8'h00, 8'hFF);
    burst(8'h00, 8'h03);
    rdc(8'h54, 32'hFF);
    rdc(8'h52, general(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1));
    repeat (4)
    begin
      gpioPins <= 4'($random(seed));
      tick(4);
      rdc(8'h53, {28'h0, gpioPins});
    end
    for (int i = 1; i < 7; i++) wr(8'h60 + i[7:0], i[0] ? 8'hA0 : 8'h40, 2'h0);
    for (int b = 0; b < 6; b++)
    begin
      sh = b >= 4 ? 16 : (b >= 2 ? 0 : 8);
      // a reading equal to a limit must stay quiet
      readings <= 24'h808080 ^ ({16'h0, b[0] ? 8'h20 : 8'hC0} << sh);
      tick(3);
      rdc(8'h57, 32'h0);
      readings <= 24'h808080 ^ ({16'h0, b[0] ? 8'h21 : 8'hBF} << sh);
      tick(3);
      readings <= 24'h808080;
      tick(3);
      rdc(8'h57, 32'h1 << b);
      rdc(8'h57, 32'h0);
    end
    levels <= 5'h03;
    rst;
    levels <= 5'h13;
    tick(3);
    rdc(8'h51, 32'h40);
    wrap_up;
  end
endmodule : tb

// file: rtl/link_status_bank.sv
// Summary of operation
// - after init, checksum-ok bit 7 set only when fuse configuration checksum passed; resets zero.
// - init-done bit 6 set once power-up initialization and fuse load finish.
// - general status bit 6 mirrors the far-end receiver lock report.
// - link-lost change flag bit 4 sets on any change of back-channel link detect.
// - link-lost flag clears on CRC error clear or forward PLL losing lock.
// - self-test error flag bit 3 sets on self-test error; errors counted separately.
// - general status bit 2 shows forward PLL lock, reset value one.
// - CRC error flag bit 1 sets on errors while link detected; clear control clears.
// - link detect bit 0 high while back-channel link valid, resets to one.
// - GPIO register bits 3:0 show live pin levels, upper bits zero.
// - eight-bit self-test CRC error count readable as whole register.
// - sixteen-bit CRC error count, low byte then high byte, reset zero.
// - temperature high alarm bit 5 above high limit, low alarm bit 4 below.
// - GPIO1 voltage high alarm bit 3 above limit, low alarm bit 2 below.
// - GPIO0 voltage high alarm bit 1 above limit, low alarm bit 0 below.
// - reading sensor status clears alarms; they set again only on new crossing.
`timescale 1ns/1ps
`include "link_status_map.svh"
module link_status_bank #(
  parameter int ADDR_W = 10
) (
  input wire logic mclk, // 100 MHz register clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic [2:0] awprot, // unused protection
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic [2:0] arprot, // unused protection
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire link_status_pkg::hw_status_s hwStatus, // link and init status, same clock
  input wire link_status_pkg::sensor_reading_s readings, // sensor readings, same clock
  input wire logic [3:0] gpioPins, // asynchronous gpio pin levels
  output logic irq // level interrupt, high while unmasked event pending
);

  if (ADDR_W < 10 || ADDR_W > 32)
  begin : g_addr_check
    $error("ADDR_W must be 10 to 32");
  end

  link_status_pkg::bank_state_s st;
  link_status_pkg::bank_state_s next_st;

  // word index, byte lanes below bit 2 ignored
  logic [7:0] arIdx;
  logic [7:0] awIdxIn;
  logic arHigh;
  logic awHigh;
  assign arIdx = araddr[9:2];
  assign awIdxIn = awaddr[9:2];

  // index bits above bit 9 must be zero for a hit
  if (ADDR_W > 10)
  begin : g_high
    assign arHigh = |araddr[ADDR_W-1:10];
    assign awHigh = |awaddr[ADDR_W-1:10];
  end
  else
  begin : g_nohigh
    assign arHigh = 1'b0;
    assign awHigh = 1'b0;
  end

  // software-writable indexes; any other write answers with an error
  function automatic logic writable(input logic [7:0] idx);
    begin
      case (idx)
        `IDX_LINK_CONTROL, `IDX_TEMP_HIGH_LIMIT, `IDX_TEMP_LOW_LIMIT,
        `IDX_VOLT0_HIGH_LIMIT, `IDX_VOLT0_LOW_LIMIT, `IDX_VOLT1_HIGH_LIMIT,
        `IDX_VOLT1_LOW_LIMIT, `IDX_IRQ_MASK: writable = 1'b1;
        default: writable = 1'b0;
      endcase
    end
  endfunction : writable

  // status registers plus every writable one
  function automatic logic readable(input logic [7:0] idx);
    begin
      case (idx)
        `IDX_INIT_RESULT, `IDX_LINK_GENERAL, `IDX_GPIO_LEVELS, `IDX_SELFTEST_COUNT,
        `IDX_CRC_COUNT_LOW, `IDX_CRC_COUNT_HIGH, `IDX_SENSOR_ALARM,
        `IDX_IRQ_STATUS: readable = 1'b1;
        default: readable = writable(idx);
      endcase
    end
  endfunction : readable

  // limits packed as temp hi, temp lo, v0 hi, v0 lo, v1 hi, v1 lo
  function automatic int limitSlot(input logic [7:0] idx);
    begin
      limitSlot = 5 - int'(idx - `IDX_TEMP_HIGH_LIMIT);
    end
  endfunction : limitSlot

  // helpers of the comb process, each given a value at its top
  logic [5:0] beyond;
  logic [7:0] generalStatus;
  logic [4:0] events;
  logic doWrite;
  logic doRead;
  logic crcHit;

  always_comb
  begin
    next_st = st;
    // alarm conditions, order matches alarm bit positions
    beyond[`BIT_TEMP_HIGH_ALARM] = readings.temp > st.limits[47:40];
    beyond[`BIT_TEMP_LOW_ALARM] = readings.temp < st.limits[39:32];
    beyond[`BIT_VOLT0_HIGH_ALARM] = readings.volt0 > st.limits[31:24];
    beyond[`BIT_VOLT0_LOW_ALARM] = readings.volt0 < st.limits[23:16];
    beyond[`BIT_VOLT1_HIGH_ALARM] = readings.volt1 > st.limits[15:8];
    beyond[`BIT_VOLT1_LOW_ALARM] = readings.volt1 < st.limits[7:0];
    // bits 7 and 5 of the general image read zero
    generalStatus = 8'h00;
    generalStatus[`BIT_REMOTE_LOCK] = st.remoteLock;
    generalStatus[`BIT_LINK_LOST_FLAG] = st.linkLostFlag;
    generalStatus[`BIT_SELFTEST_ERROR_FLAG] = st.selftestFlag;
    generalStatus[`BIT_FWD_PLL_LOCKED] = st.pllLock;
    generalStatus[`BIT_CRC_ERROR_FLAG] = st.crcErrFlag;
    generalStatus[`BIT_BC_LINK_VALID] = st.linkValid;
    // registered link valid gates errors, so noise at the instant of link return is not counted
    crcHit = hwStatus.crcErrorPulse && st.linkValid;
    events = 5'h00;
    doWrite = 1'b0;
    doRead = 1'b0;

    // live status, sampled every cycle
    // pins change with no regard to mclk: two flops before anything reads them
    next_st.gpioMeta = gpioPins;
    next_st.gpioLevels = st.gpioMeta;
    next_st.remoteLock = hwStatus.remoteLocked;
    next_st.linkValid = hwStatus.bcLinkValid;
    next_st.pllLock = hwStatus.fwdPllLocked;
    next_st.prevInitDone = hwStatus.initDone;
    next_st.prevBeyond = beyond;
    next_st.crcClear = 1'b0;

    // checksum result latched with the init completion edge
    if (hwStatus.initDone && !st.prevInitDone && !st.initDone)
    begin
      next_st.initDone = 1'b1;
      next_st.cksumOk = hwStatus.checksumOk;
    end

    // write channel: address and data taken independently
    if (awvalid && st.awready)
    begin
      next_st.awHeld = 1'b1;
      next_st.awIdx = awIdxIn;
      next_st.awOk = !awHigh && writable(awIdxIn);
    end
    if (wvalid && st.wready)
    begin
      next_st.wHeld = 1'b1;
      next_st.wData = wdata[7:0];
      next_st.wLane0 = wstrb[0];
    end
    // write answer comes one cycle after the later half is taken
    case (st.wrState)
      link_status_pkg::WR_IDLE:
      begin
        // both halves in: readies stay low until the answer is taken
        if (next_st.awHeld && next_st.wHeld)
        begin
          doWrite = next_st.awOk && next_st.wLane0;
          next_st.bresp = next_st.awOk ? `RESP_OKAY : `RESP_SLVERR;
          next_st.bvalid = 1'b1;
          next_st.awHeld = 1'b0;
          next_st.wHeld = 1'b0;
          next_st.wrState = link_status_pkg::WR_RESP;
        end
      end
      link_status_pkg::WR_RESP:
      begin
        if (bready)
        begin
          next_st.bvalid = 1'b0;
          next_st.wrState = link_status_pkg::WR_IDLE;
        end
      end
      default:
      begin
        // stray state code: drop the answer and return to idle
        next_st.bvalid = 1'b0;
        next_st.wrState = link_status_pkg::WR_IDLE;
      end
    endcase
    next_st.awready = !next_st.awHeld && (next_st.wrState == link_status_pkg::WR_IDLE);
    next_st.wready = !next_st.wHeld && (next_st.wrState == link_status_pkg::WR_IDLE);

    // the clear bit is a one-cycle strobe, so it reads back as zero
    if (doWrite)
    begin
      case (next_st.awIdx)
        `IDX_LINK_CONTROL:
          next_st.crcClear = next_st.wData[`BIT_CRC_ERROR_CLEAR];
        `IDX_IRQ_MASK:
          next_st.irqMask = next_st.wData[4:0];
        `IDX_TEMP_HIGH_LIMIT, `IDX_TEMP_LOW_LIMIT, `IDX_VOLT0_HIGH_LIMIT,
        `IDX_VOLT0_LOW_LIMIT, `IDX_VOLT1_HIGH_LIMIT, `IDX_VOLT1_LOW_LIMIT:
          next_st.limits[limitSlot(next_st.awIdx)*8 +: 8] = next_st.wData;
        default:
        begin
          // writable() admits no other index
        end
      endcase
    end

    // read channel, side effects happen when the address is taken
    if (rvalid && rready)
    begin
      next_st.rvalid = 1'b0;
    end
    // no new address while an answer still stands
    if (arvalid && st.arready)
    begin
      doRead = 1'b1;
      next_st.rvalid = 1'b1;
      next_st.rresp = (!arHigh && readable(arIdx)) ? `RESP_OKAY : `RESP_SLVERR;
      next_st.rdata = 32'h0000_0000;
      // unused upper bits of every register read zero
      if (!arHigh)
      begin
        case (arIdx)
          `IDX_INIT_RESULT:
            next_st.rdata[7:0] = {st.cksumOk, st.initDone, 6'h00};
          `IDX_LINK_GENERAL:
            next_st.rdata[7:0] = generalStatus;
          `IDX_GPIO_LEVELS:
            next_st.rdata[7:0] = {4'h0, st.gpioLevels};
          `IDX_SELFTEST_COUNT:
            next_st.rdata[7:0] = st.selftestCount;
          `IDX_CRC_COUNT_LOW:
            next_st.rdata[7:0] = st.crcCount[7:0];
          `IDX_CRC_COUNT_HIGH:
            next_st.rdata[7:0] = st.crcCount[15:8];
          `IDX_SENSOR_ALARM:
            next_st.rdata[7:0] = {2'h0, st.alarms};
          `IDX_LINK_CONTROL:
            next_st.rdata[7:0] = 8'h00; // clear bit self-clears, reads zero
          `IDX_TEMP_HIGH_LIMIT, `IDX_TEMP_LOW_LIMIT, `IDX_VOLT0_HIGH_LIMIT,
          `IDX_VOLT0_LOW_LIMIT, `IDX_VOLT1_HIGH_LIMIT, `IDX_VOLT1_LOW_LIMIT:
            next_st.rdata[7:0] = st.limits[limitSlot(arIdx)*8 +: 8];
          `IDX_IRQ_STATUS:
            next_st.rdata[7:0] = {3'h0, st.irqStatus};
          `IDX_IRQ_MASK:
            next_st.rdata[7:0] = {3'h0, st.irqMask};
          default:
            next_st.rdata[7:0] = 8'h00;
        endcase
      end
    end
    next_st.arready = !next_st.rvalid;

    // clears first, so a same-cycle set below wins
    if (doRead && !arHigh && arIdx == `IDX_SENSOR_ALARM)
    begin
      next_st.alarms = 6'h00;
    end
    if (doRead && !arHigh && arIdx == `IDX_IRQ_STATUS)
    begin
      next_st.irqStatus = 5'h00;
    end
    // self-test flag rides on the same clear; nothing else would ever drop it
    if (st.crcClear)
    begin
      next_st.crcErrFlag = 1'b0;
      next_st.linkLostFlag = 1'b0;
      next_st.crcCount = 16'h0000;
      next_st.selftestFlag = 1'b0;
    end
    // lock loss is the falling edge against the registered copy
    if (st.pllLock && !hwStatus.fwdPllLocked)
    begin
      next_st.linkLostFlag = 1'b0;
      events[`IRQ_PLL_LOST] = 1'b1;
    end

    // sets
    // either direction counts, so a link that is down at release flags at once
    if (hwStatus.bcLinkValid != st.linkValid)
    begin
      next_st.linkLostFlag = 1'b1;
      events[`IRQ_LINK_CHANGE] = 1'b1;
    end
    if (crcHit)
    begin
      next_st.crcErrFlag = 1'b1;
      events[`IRQ_CRC_ERROR] = 1'b1;
      // saturate rather than wrap; an error during a clear leaves a count of one
      if (!st.crcClear && st.crcCount != 16'hFFFF)
      begin
        next_st.crcCount = st.crcCount + 16'h0001;
      end
      else if (st.crcClear)
      begin
        next_st.crcCount = 16'h0001;
      end
    end
    if (hwStatus.selftestErrorPulse)
    begin
      next_st.selftestFlag = 1'b1;
      events[`IRQ_SELFTEST_ERROR] = 1'b1;
      // saturation keeps the count from wrapping to a misleading small value
      if (st.selftestCount != 8'hFF)
      begin
        next_st.selftestCount = st.selftestCount + 8'h01;
      end
    end
    // only a fresh crossing sets an alarm, so a held excursion stays cleared after a read
    if (|(beyond & ~st.prevBeyond))
    begin
      next_st.alarms = next_st.alarms | (beyond & ~st.prevBeyond);
      events[`IRQ_SENSOR_ALARM] = 1'b1;
    end
    // irq from the next status, so it rises with the sticky bit, not a cycle later
    next_st.irqStatus = next_st.irqStatus | events;
    next_st.irq = |(next_st.irqStatus & next_st.irqMask);
  end

  // limits reset wide open, so nothing alarms until software narrows them
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      // clear everything, then the few fields with their own reset values
      st <= '0;
      st.wrState <= link_status_pkg::WR_IDLE;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.pllLock <= `RST_FWD_PLL_LOCKED;
      st.linkValid <= `RST_BC_LINK_VALID;
      st.limits <= {`RST_HIGH_LIMIT, `RST_LOW_LIMIT, `RST_HIGH_LIMIT, `RST_LOW_LIMIT,
                    `RST_HIGH_LIMIT, `RST_LOW_LIMIT};
      st.irqMask <= `RST_IRQ_MASK;
      // all-ones prior state stops a reading already beyond a limit from alarming at release
      st.prevBeyond <= 6'h3F;
    end
    else
    begin
      st <= next_st;
    end
  end

  // every output straight from the state register
  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign irq = st.irq;

endmodule : link_status_bank

// file: rtl/link_status_map.svh
`ifndef LINK_STATUS_MAP_SVH
`define LINK_STATUS_MAP_SVH
// register indexes, byte address is four times the index
`define IDX_INIT_RESULT 8'h51
`define IDX_LINK_GENERAL 8'h52
`define IDX_GPIO_LEVELS 8'h53
`define IDX_SELFTEST_COUNT 8'h54
`define IDX_CRC_COUNT_LOW 8'h55
`define IDX_CRC_COUNT_HIGH 8'h56
`define IDX_SENSOR_ALARM 8'h57
`define IDX_LINK_CONTROL 8'h60
`define IDX_TEMP_HIGH_LIMIT 8'h61
`define IDX_TEMP_LOW_LIMIT 8'h62
`define IDX_VOLT0_HIGH_LIMIT 8'h63
`define IDX_VOLT0_LOW_LIMIT 8'h64
`define IDX_VOLT1_HIGH_LIMIT 8'h65
`define IDX_VOLT1_LOW_LIMIT 8'h66
`define IDX_IRQ_STATUS 8'h68
`define IDX_IRQ_MASK 8'h69
// field positions
`define BIT_CFG_CHECKSUM_OK 7
`define BIT_INIT_DONE 6
`define BIT_REMOTE_LOCK 6
`define BIT_LINK_LOST_FLAG 4
`define BIT_SELFTEST_ERROR_FLAG 3
`define BIT_FWD_PLL_LOCKED 2
`define BIT_CRC_ERROR_FLAG 1
`define BIT_BC_LINK_VALID 0
`define BIT_CRC_ERROR_CLEAR 3
`define BIT_TEMP_HIGH_ALARM 5
`define BIT_TEMP_LOW_ALARM 4
`define BIT_VOLT1_HIGH_ALARM 3
`define BIT_VOLT1_LOW_ALARM 2
`define BIT_VOLT0_HIGH_ALARM 1
`define BIT_VOLT0_LOW_ALARM 0
// interrupt status bits
`define IRQ_CRC_ERROR 0
`define IRQ_SELFTEST_ERROR 1
`define IRQ_LINK_CHANGE 2
`define IRQ_PLL_LOST 3
`define IRQ_SENSOR_ALARM 4
// reset values
`define RST_FWD_PLL_LOCKED 1'b1
`define RST_BC_LINK_VALID 1'b1
`define RST_HIGH_LIMIT 8'hFF
`define RST_LOW_LIMIT 8'h00
`define RST_IRQ_MASK 5'h00
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: rtl/link_status_pkg.sv
package link_status_pkg;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_e;

  typedef struct packed {
    logic initDone;
    logic checksumOk;
    logic remoteLocked;
    logic bcLinkValid;
    logic fwdPllLocked;
    logic crcErrorPulse;
    logic selftestErrorPulse;
  } hw_status_s;

  typedef struct packed {
    logic [7:0] temp;
    logic [7:0] volt0;
    logic [7:0] volt1;
  } sensor_reading_s;

  typedef struct packed {
    wr_state_e wrState;
    logic awHeld;
    logic [7:0] awIdx;
    logic awOk;
    logic wHeld;
    logic [7:0] wData;
    logic wLane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic initDone;
    logic cksumOk;
    logic prevInitDone;
    logic remoteLock;
    logic linkValid;
    logic pllLock;
    logic linkLostFlag;
    logic crcErrFlag;
    logic selftestFlag;
    logic [7:0] selftestCount;
    logic [15:0] crcCount;
    logic crcClear;
    logic [5:0] alarms;
    logic [5:0] prevBeyond;
    logic [47:0] limits;
    logic [3:0] gpioMeta;
    logic [3:0] gpioLevels;
    logic [4:0] irqStatus;
    logic [4:0] irqMask;
    logic irq;
  } bank_state_s;
endpackage : link_status_pkg
